// ==== rtl/csb_pkg.sv ====
// package for the processor sideband control block
// assumes one 20 MHz clock, pci and rtc rates given as one-cycle enables
package csb_pkg;
	// clock figures
	localparam int CLK_NS = 50;
	// hold after stop-clock release, in pci bus clocks
	localparam int STOP_HOLD_PCLKS = 5;
	localparam logic [2:0] STOP_HOLD_CNT = 3'(STOP_HOLD_PCLKS);
	// suspend pulse length, in rtc clock periods (three to four)
	localparam int SUS_RTC_MIN = 3;
	localparam logic [2:0] SUS_RTC_CNT = 3'(SUS_RTC_MIN + 1);
	// i/o ports
	localparam logic [15:0] PWR_CMD_PORT = 16'h00B2;
	localparam logic [15:0] RST_CTL_PORT = 16'h00C9;
	localparam int RST_HARD_BIT = 2;
	localparam int RST_SOFT_BIT = 1;

	// the four signals headed to the processor
	typedef struct packed {
		logic nmi;
		logic smi;
		logic irq;
		logic init;
	} csb_cpu_sig_s;

	// one i/o write seen on the bus
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic [7:0]  data;
	} csb_io_wr_s;

	typedef enum logic [1:0] {
		CSB_RUN,
		CSB_SUS_PULSE,
		CSB_COLD
	} csb_rst_e;
endpackage

// ==== rtl/csb_sideband.sv ====
// processor sideband control: interrupt/init/reset outputs and hard reset
// assumes inputs synchronous to i_ref_clk; pci and rtc ticks are enables
`timescale 1ns/1ns
`default_nettype none
// What this block does
// RULE1: strap low: signals pass straight through
// RULE2: strap high: latch during stop-clock, hold five
// RULE3: strap high active low, low active high
// RULE4: smi may wait for stop-clock release
// RULE5: smi on monitor trap or command port
// RULE6: hard reset on C9h write bits 2,1
// RULE7: suspend planes low three to four rtc
// RULE8: power loss in pulse means cold boot
module csb_sideband (
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_nrst,
	input  wire logic                  i_pci_tick,
	input  wire logic                  i_rtc_tick,
	input  wire logic                  i_cpu_type,
	input  wire logic                  i_stop_clock_request,
	input  wire csb_pkg::csb_cpu_sig_s i_cpu_sig,
	input  wire logic                  i_monitor_trap,
	input  wire csb_pkg::csb_io_wr_s   i_io_wr,
	input  wire logic                  i_power_good_in,
	output logic                       o_nmi,
	output logic                       o_system_mgmt_interrupt,
	output logic                       o_cpu_irq_request,
	output logic                       o_init,
	output logic                       o_cpu_hard_reset_out,
	output logic                       o_suspend_plane_a_n,
	output logic                       o_suspend_plane_c_n,
	output logic                       o_cold_boot
);
	import csb_pkg::*;

	csb_cpu_sig_s held_r, held_nxt;
	logic         stop_d_r, stop_d_nxt;
	logic         hold_r, hold_nxt;
	logic [2:0]   hold_cnt_r, hold_cnt_nxt;
	logic         trap_r, trap_nxt;
	csb_rst_e     st_r, st_nxt;
	logic [2:0]   sus_cnt_r, sus_cnt_nxt;
	logic         pg_lost_r, pg_lost_nxt;
	logic         strap_r, strap_nxt;
	csb_cpu_sig_s out_r, out_nxt;
	logic         rst_r, rst_nxt;
	logic         sus_r, sus_nxt;
	logic         cold_r, cold_nxt;
	logic         io_trap;
	logic         hard_req;
	csb_cpu_sig_s live;

	// polarity for an active-high level given the strap
	function automatic logic pol(input logic lvl, input logic strap);
		return strap ? ~lvl : lvl;
	endfunction

	// latch, hold and trap path
	always_comb begin
		// RULE5: trap smi sources
		io_trap = i_monitor_trap |
			(i_io_wr.valid && i_io_wr.addr == PWR_CMD_PORT);
		// RULE6: hard reset command decode
		hard_req = i_io_wr.valid && i_io_wr.addr == RST_CTL_PORT &&
			i_io_wr.data[RST_HARD_BIT] && i_io_wr.data[RST_SOFT_BIT];
		strap_nxt = strap_r;
		if (st_r == CSB_COLD)
			strap_nxt = i_cpu_type; // strap re-caught after reset release
		stop_d_nxt = i_stop_clock_request;
		held_nxt = held_r;
		hold_nxt = hold_r;
		hold_cnt_nxt = hold_cnt_r;
		// RULE2: capture on request assertion
		if (i_stop_clock_request && !stop_d_r) begin
			held_nxt = i_cpu_sig;
			hold_nxt = 1'b1;
			hold_cnt_nxt = STOP_HOLD_CNT;
		end else if (hold_r && !i_stop_clock_request && i_pci_tick) begin
			// count five pci clocks after the request is gone
			if (hold_cnt_r <= 3'h1)
				hold_nxt = 1'b0;
			hold_cnt_nxt = hold_cnt_r - 3'h1;
		end
		// RULE4: a trap during stop-clock waits for the release
		trap_nxt = trap_r;
		if (io_trap && (i_stop_clock_request || hold_r))
			trap_nxt = 1'b1;
		else if (!hold_r && !i_stop_clock_request)
			trap_nxt = 1'b0;
		// a trap met during the hold fires once, at release, not twice
		live = i_cpu_sig;
		live.smi = i_cpu_sig.smi |
			(io_trap & ~i_stop_clock_request & ~hold_r) |
			(trap_r & ~hold_r & ~i_stop_clock_request);
		out_nxt = live;
		// RULE1: strap low never latches
		// RULE2: strap high holds the captured values
		if (strap_r && (hold_r || (i_stop_clock_request && !stop_d_r)))
			out_nxt = (i_stop_clock_request && !stop_d_r) ? i_cpu_sig
				: held_r;
	end

	// hard reset sequencer
	always_comb begin
		st_nxt = st_r;
		sus_cnt_nxt = sus_cnt_r;
		pg_lost_nxt = pg_lost_r;
		rst_nxt = 1'b0;
		sus_nxt = 1'b1;
		cold_nxt = 1'b0;
		case (st_r)
			CSB_RUN: begin
				if (hard_req) begin
					// RULE7: planes drop at once
					st_nxt = CSB_SUS_PULSE;
					sus_cnt_nxt = SUS_RTC_CNT;
					pg_lost_nxt = 1'b0;
					sus_nxt = 1'b0;
					rst_nxt = 1'b1;
				end
			end
			CSB_SUS_PULSE: begin
				sus_nxt = 1'b0;
				rst_nxt = 1'b1;
				// RULE8: watch power good through the pulse
				if (!i_power_good_in)
					pg_lost_nxt = 1'b1;
				// first rtc tick may be partial: 4 ticks give 3..4 periods
				if (i_rtc_tick)
					sus_cnt_nxt = sus_cnt_r - 3'h1;
				if (i_rtc_tick && sus_cnt_r == 3'h1) begin
					sus_nxt = 1'b1;
					// RULE8: cold boot or normal reboot
					if (pg_lost_r || !i_power_good_in)
						st_nxt = CSB_COLD;
					else
						st_nxt = CSB_RUN;
					rst_nxt = pg_lost_r || !i_power_good_in;
					cold_nxt = rst_nxt;
				end
			end
			CSB_COLD: begin
				// held in reset until power returns, then full power-up
				rst_nxt = 1'b1;
				cold_nxt = 1'b1;
				if (i_power_good_in) begin
					st_nxt = CSB_RUN;
					rst_nxt = 1'b0;
					cold_nxt = 1'b0;
				end
			end
			default: st_nxt = CSB_RUN;
		endcase
	end

	// registers; the strap is caught in the first cycle after release
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			held_r     <= '0;
			stop_d_r   <= 1'b0;
			hold_r     <= 1'b0;
			hold_cnt_r <= 3'h0;
			trap_r     <= 1'b0;
			st_r       <= CSB_COLD;
			sus_cnt_r  <= 3'h0;
			pg_lost_r  <= 1'b0;
			strap_r    <= 1'b0;
			out_r      <= '0;
			rst_r      <= 1'b1;
			sus_r      <= 1'b1;
			cold_r     <= 1'b1;
		end else begin
			held_r     <= held_nxt;
			stop_d_r   <= stop_d_nxt;
			hold_r     <= hold_nxt;
			hold_cnt_r <= hold_cnt_nxt;
			trap_r     <= trap_nxt;
			st_r       <= st_nxt;
			sus_cnt_r  <= sus_cnt_nxt;
			pg_lost_r  <= pg_lost_nxt;
			strap_r    <= strap_nxt;
			out_r      <= out_nxt;
			rst_r      <= rst_nxt;
			sus_r      <= sus_nxt;
			cold_r     <= cold_nxt;
		end
	end

	// output pins: init and hard reset polarity follows the strap, the rest are passed as they are
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			o_nmi                   <= 1'b0;
			o_system_mgmt_interrupt <= 1'b0;
			o_cpu_irq_request       <= 1'b0;
			o_init                  <= 1'b0;
			o_cpu_hard_reset_out    <= 1'b0;
			o_suspend_plane_a_n     <= 1'b1;
			o_suspend_plane_c_n     <= 1'b1;
			o_cold_boot             <= 1'b0;
		end else begin
			o_nmi                   <= out_r.nmi;
			o_system_mgmt_interrupt <= out_r.smi;
			o_cpu_irq_request       <= out_r.irq;
			// RULE3: strap-driven polarity
			o_init                  <= pol(out_r.init, strap_r);
			o_cpu_hard_reset_out    <= pol(rst_r, strap_r);
			o_suspend_plane_a_n     <= sus_r;
			o_suspend_plane_c_n     <= sus_r;
			o_cold_boot             <= cold_r;
		end
	end

	// RULE7: a hard reset request drops both planes within two cycles
	a_sus_drop: assert property ( // RULE7
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(st_r == CSB_RUN && hard_req) |->
		##2 (!o_suspend_plane_a_n && !o_suspend_plane_c_n));
	// RULE3: reset pin tracks the strap polarity
	a_rst_pol: assert property ( // RULE3
		@(posedge i_ref_clk) disable iff (!i_nrst)
		$stable(strap_r) |=> o_cpu_hard_reset_out ==
		($past(strap_r) ? ~$past(rst_r) : $past(rst_r)));
	// RULE1: strap low passes nmi in two cycles, stop-clock or not
	a_pass_thru: assert property ( // RULE1
		@(posedge i_ref_clk) disable iff (!i_nrst)
		!strap_r ##1 !strap_r |=>
		o_nmi == $past(i_cpu_sig.nmi, 2));
	// RULE2: strap high shows the captured irq while holding
	a_hold_irq: assert property ( // RULE2
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(strap_r && hold_r && !(i_stop_clock_request && !stop_d_r)) |->
		##2 o_cpu_irq_request == $past(held_r.irq, 2));
	// RULE5: command port write raises smi when not throttled
	a_port_smi: assert property ( // RULE5
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(i_io_wr.valid && i_io_wr.addr == PWR_CMD_PORT &&
		!i_stop_clock_request && !hold_r) |-> ##2 o_system_mgmt_interrupt);
	// RULE4: a deferred trap is never dropped while waiting
	a_trap_keep: assert property ( // RULE4
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(trap_r && hold_r) |=> trap_r);
	// RULE4: a deferred trap fires smi once the hold is over
	a_trap_fire: assert property ( // RULE4
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(trap_r && !hold_r && $past(hold_r) && !i_stop_clock_request) |->
		##2 o_system_mgmt_interrupt);
	// RULE6: the reset command starts the pulse
	a_hard_start: assert property ( // RULE6
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(st_r == CSB_RUN && hard_req) |=> st_r == CSB_SUS_PULSE);
	// RULE8: power lost in the pulse ends in cold boot
	a_cold_path: assert property ( // RULE8
		@(posedge i_ref_clk) disable iff (!i_nrst)
		(st_r == CSB_SUS_PULSE && pg_lost_r && i_rtc_tick &&
		sus_cnt_r == 3'h1) |=> st_r == CSB_COLD);
endmodule
`default_nettype wire

// ==== sim/csb_cpu_model.sv ====
// processor side model: decodes init and reset with the strap polarity
// assumes the strap level is held steady between resets
`timescale 1ns/1ns
`default_nettype none
module csb_cpu_model (
	input  wire logic i_cpu_type,
	input  wire logic i_init,
	input  wire logic i_cpu_hard_reset_out,
	output logic      o_init_act,
	output logic      o_reset_act
);
	// polarity by strap
	// strap high means both lines are read as active low
	assign o_init_act  = i_init ^ i_cpu_type;
	assign o_reset_act = i_cpu_hard_reset_out ^ i_cpu_type;
endmodule
`default_nettype wire

// ==== sim/csb_sideband_tb_top.sv ====
// bench for the processor sideband block, one task per scenario
// assumes csb_pkg, csb_sideband and csb_cpu_model compiled first
`timescale 1ns/1ns
`default_nettype none
module csb_sideband_tb_top;
	import csb_pkg::*;
	logic         clk, nrst, pci, rtc, strap, stop, trap, pgood;
	logic         nmi, smi, irq, init, hrst, sa_n, sc_n, cold, i_act, r_act;
	logic [2:0]   div;
	csb_cpu_sig_s sig;
	csb_io_wr_s   wr;
	int           miscompares, compares, cycles, at;
	csb_sideband uut (.i_ref_clk(clk), .i_nrst(nrst), .i_pci_tick(pci),
		.i_rtc_tick(rtc), .i_cpu_type(strap), .i_stop_clock_request(stop),
		.i_cpu_sig(sig), .i_monitor_trap(trap), .i_io_wr(wr),
		.i_power_good_in(pgood), .o_nmi(nmi), .o_system_mgmt_interrupt(smi),
		.o_cpu_irq_request(irq), .o_init(init), .o_cpu_hard_reset_out(hrst),
		.o_suspend_plane_a_n(sa_n), .o_suspend_plane_c_n(sc_n),
		.o_cold_boot(cold));
	csb_cpu_model cpu (.i_cpu_type(strap), .i_init(init),
		.i_cpu_hard_reset_out(hrst), .o_init_act(i_act), .o_reset_act(r_act));
	// free clock, 50 ns period
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// pci tick every 2 cycles, rtc tick every 8, moved just after the edge
	always @(posedge clk) #1 begin
		div = div + 3'h1;
		pci = div[0];
		rtc = (div == 3'h7);
	end
	// a hang is cut short well past the few hundred cycles needed
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			conclude();
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// strap is only taken on leaving reset, so each mode gets a reset
	task automatic do_reset(input logic s);
		nrst = 1'b0;
		strap = s;
		stop = 1'b0;
		pgood = 1'b1;
		step(6);
		nrst = 1'b1;
		step(5);
	endtask
	task automatic io_write(input logic [15:0] a, input logic [7:0] d);
		wr = '{1'b1, a, d};
		step(1);
		wr.valid = 1'b0;
	endtask
	// cycle of the first smi pulse within n cycles, or -1
	task automatic smi_within(input int n, output int first);
		first = -1;
		for (int k = 0; k < n; k++) begin
			if (first < 0 && smi === 1'b1) first = k;
			step(1);
		end
	endtask
	task automatic t_pass();
		do_reset(1'b0);
		sig = csb_cpu_sig_s'(4'hB);
		step(3);
		check({nmi, irq, i_act, r_act}, 16'h000E);
		stop = 1'b1;
		sig = csb_cpu_sig_s'(4'h6);
		step(3);
		check({nmi, smi, irq, i_act}, 16'h0006);
		stop = 1'b0;
		sig = '0;
	endtask
	task automatic t_hold();
		do_reset(1'b1);
		check({init, hrst, i_act, r_act}, 16'h000C);
		stop = 1'b1;
		step(3);
		sig = csb_cpu_sig_s'(4'h9);
		step(3);
		check({nmi, init}, 16'h0001);
		stop = 1'b0;
		at = 0;
		while (nmi !== 1'b1 && at < 30) begin
			step(1);
			at++;
		end
		check(16'(at >= 9 && at <= 15), 16'h0001);
		check(16'(i_act), 16'h0001);
		sig = '0;
	endtask
	task automatic t_smi();
		io_write(PWR_CMD_PORT, 8'h00);
		smi_within(5, at);
		check(16'(at >= 0), 16'h0001);
		io_write(16'h00B3, 8'h00);
		smi_within(5, at);
		check(16'(at), 16'hFFFF);
		trap = 1'b1;
		step(1);
		trap = 1'b0;
		smi_within(5, at);
		check(16'(at >= 0), 16'h0001);
		stop = 1'b1;
		trap = 1'b1;
		step(1);
		trap = 1'b0;
		smi_within(8, at);
		check(16'(at), 16'hFFFF);
		stop = 1'b0;
		smi_within(20, at);
		check(16'(at >= 8 && at <= 16), 16'h0001);
	endtask
	task automatic t_hard();
		do_reset(1'b0);
		io_write(RST_CTL_PORT, 8'h04);
		step(3);
		check({sa_n, sc_n}, 16'h0003);
		io_write(RST_CTL_PORT, 8'h06);
		step(1);
		check({sa_n, sc_n, r_act}, 16'h0001);
		at = 0;
		while (sa_n !== 1'b1 && at < 60) begin
			step(1);
			at++;
		end
		check(16'(at >= 20 && at <= 34), 16'h0001);
		step(2);
		check({cold, r_act}, 16'h0000);
		io_write(RST_CTL_PORT, 8'h06);
		step(4);
		pgood = 1'b0;
		step(50);
		check({sc_n, cold, r_act}, 16'h0007);
		pgood = 1'b1;
		step(4);
		check({cold, r_act}, 16'h0000);
	endtask
	// all inputs set at time zero, then the scenarios in turn
	initial begin
		{nrst, pci, rtc, strap, stop, trap, pgood, div} = '0;
		sig = '0;
		wr = '0;
		miscompares = 0;
		compares = 0;
		cycles = 0;
		#1;
		t_pass();
		t_hold();
		t_smi();
		t_hard();
		conclude();
	end
endmodule
`default_nettype wire
